//--- inc/csup_pkg.sv
// Shared constants, types and register map of the charger safety supervisor.
package csup_pkg;

  // System clock and one-second timer tick.
  localparam int unsigned CSUP_CLK_HZ = 200_000_000;
  localparam int unsigned CSUP_TICK_PERIOD_S = 1;
  localparam int unsigned CSUP_TICK_CYCLES = CSUP_CLK_HZ * CSUP_TICK_PERIOD_S;

  // Die temperature thresholds in degrees C, and the derating slope span.
  localparam logic [7:0] CSUP_DIE_DERATE_C = 8'h73;
  localparam logic [7:0] CSUP_DIE_ZERO_C = 8'h96;
  localparam logic [7:0] CSUP_DIE_OT_C = 8'h9b;
  localparam logic [15:0] CSUP_DIE_SPAN_C = 16'h0023;
  localparam logic [6:0] CSUP_PCT_FULL = 7'h64;
  localparam logic [15:0] CSUP_PCT_FULL_W = 16'h0064;
  localparam logic [6:0] CSUP_PCT_ZERO = 7'h00;

  // Safety timer limits in seconds.
  localparam logic [13:0] CSUP_PRE_LIMIT_S = 14'h0fa0;
  localparam logic [13:0] CSUP_FAST_LIMIT_S = 14'h2ee0;
  localparam logic [13:0] CSUP_TMR_ONE = 14'h0001;
  localparam logic [13:0] CSUP_TMR_ZERO = 14'h0000;

  // Termination voltage reductions in mV for the warm zones.
  localparam logic [7:0] CSUP_VTERM_WARM_MV = 8'h64;
  localparam logic [7:0] CSUP_VTERM_HOT_MV = 8'h96;
  localparam logic [7:0] CSUP_VTERM_NONE_MV = 8'h00;

  // Path-resistance compensation step per code, in milliohms (code 7 = 420).
  localparam logic [7:0] CSUP_CORD_STEP_MOHM = 8'h3c;

  // Register byte offsets.
  localparam logic [11:0] CSUP_CTRL_OFS = 12'h000;
  localparam logic [11:0] CSUP_STATUS_OFS = 12'h004;
  localparam logic [11:0] CSUP_INT_STAT_OFS = 12'h008;
  localparam logic [11:0] CSUP_INT_MASK_OFS = 12'h00c;
  localparam logic [11:0] CSUP_PRE_TMR_OFS = 12'h010;
  localparam logic [11:0] CSUP_FAST_TMR_OFS = 12'h014;
  localparam logic [11:0] CSUP_ZONE_CFG_OFS = 12'h0d0;

  // Control register fields.
  localparam int unsigned CSUP_CTRL_EN_BIT = 0;
  localparam int unsigned CSUP_CTRL_DERATE_DIS_BIT = 1;
  localparam int unsigned CSUP_CTRL_MANUAL_BIT = 2;
  localparam int unsigned CSUP_CTRL_CORD_LSB = 4;
  localparam int unsigned CSUP_CTRL_CORD_MSB = 6;
  localparam logic [6:0] CSUP_CTRL_RST = 7'h01;
  localparam int unsigned CSUP_ZONE_OPT_BIT = 6;

  // Interrupt event bits.
  localparam int unsigned CSUP_EV_ZONE = 0;
  localparam int unsigned CSUP_EV_BAT_LOW = 1;
  localparam int unsigned CSUP_EV_PRESENCE = 2;
  localparam int unsigned CSUP_EV_SOURCE = 3;
  localparam int unsigned CSUP_EV_PHASE = 4;
  localparam int unsigned CSUP_EV_DIE_OT = 5;
  localparam int unsigned CSUP_EV_FAULT = 6;
  localparam int unsigned CSUP_EV_NUM = 7;

  // Battery temperature zones, Gray coded from cold to hot.
  typedef enum logic [2:0] {
    CSUP_ZONE_COLD = 3'b000,
    CSUP_ZONE_COOL = 3'b001,
    CSUP_ZONE_NORMAL = 3'b011,
    CSUP_ZONE_WARM = 3'b010,
    CSUP_ZONE_HOT = 3'b110,
    CSUP_ZONE_OVER = 3'b111
  } csup_zone_t;

  // Supervisor states.
  typedef enum logic [1:0] {
    CSUP_ST_IDLE = 2'b00,
    CSUP_ST_RUN = 2'b01,
    CSUP_ST_SUSPEND = 2'b11,
    CSUP_ST_FAULT = 2'b10
  } csup_state_t;

  // Inputs from the analog charger, comparators and source detection.
  typedef struct packed {
    logic ntc_present;
    logic ntc_below_0c;
    logic ntc_below_10c;
    logic ntc_above_45c;
    logic ntc_above_50c;
    logic ntc_above_60c;
    logic vsys_above_bat;
    logic bat_below_vpre;
    logic bat_low;
    logic source_present;
    logic vin_reg_active;
    logic iin_reg_active;
    logic [2:0] charge_phase;
    logic [7:0] die_temp_c;
  } csup_pins_t;

  // Commands to the analog charge loop.
  typedef struct packed {
    logic charge_run;
    logic current_half;
    logic [6:0] derate_pct;
    logic [7:0] vterm_drop_mv;
    logic [2:0] cord_comp_setting;
    logic fault;
  } csup_cmd_t;

endpackage : csup_pkg

//--- rtl/csup_supervisor.sv
// Charger safety supervisor: derating, zone policy, safety timers, status and APB registers.
//
// Overview of operation
// - Derate current linearly 115C down to zero 150C.
// - At 155C: interrupt, overtemp status, charge fault.
// - Derate disable bit turns off die regulation.
// - Below 0C suspend charging, stop both timers.
// - Above 60C suspend charging, stop both timers.
// - 0C to 10C: option bit halves currents.
// - Halved cool zone: half-speed timers, trickle unchanged.
// - 10C to 45C: normal currents, voltage, timers.
// - 45C to 50C: option suspends, else minus 100mV.
// - 50C to 60C: option suspends, else minus 150mV.
// - Stopped timers keep count, resume from it.
// - 4000s precondition timer while enabled below threshold.
// - Precondition timer expiry enters fault, stops charging.
// - 12000s fast timer while above precharge threshold.
// - Fast timer expiry enters fault, stops charging.
// - Temperature suspension halts both safety timers.
// - Input or thermal regulation halves timer speed.
// - Three-bit compensation code, zero disables it.
// - Interrupt on zone, battery, source, phase changes.
// - Thermistor pull-down means battery present.
// - Enable bit overrides automatic charger enable.
//
// Decided for this implementation: the address map and register access over APB.
module csup_supervisor
  import csup_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = CSUP_TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire csup_pins_t pins_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output csup_cmd_t cmd_ff,
  output logic irq_ff
);

  csup_pins_t pins_meta_ff;
  csup_pins_t pins_ff;
  csup_zone_t zone_ff;
  csup_zone_t nxt_zone;
  csup_zone_t zone_prev_ff;
  csup_state_t state_ff;
  csup_state_t nxt_state;
  logic [6:0] ctrl_ff;
  logic zone_opt_ff;
  logic [CSUP_EV_NUM-1:0] int_stat_ff;
  logic [CSUP_EV_NUM-1:0] nxt_int_stat;
  logic [CSUP_EV_NUM-1:0] int_mask_ff;
  logic [CSUP_EV_NUM-1:0] events;
  logic [13:0] pre_cnt_ff;
  logic [13:0] fast_cnt_ff;
  logic [31:0] tick_cnt_ff;
  logic tick;
  logic half_ph_ff;
  logic count_en;
  logic slow_timers;
  logic enabled;
  logic derate_active;
  logic die_ot;
  logic die_ot_ff;
  logic fault_ff;
  logic zone_suspend;
  logic zone_half;
  logic pre_expired;
  logic fast_expired;
  logic [6:0] nxt_derate_pct;
  logic [15:0] derate_diff;
  logic [15:0] derate_prod;
  logic [4:0] prev_bits_ff;
  logic [2:0] phase_prev_ff;
  logic apb_access;
  logic apb_commit;
  logic wr_commit;
  logic [31:0] rd_data;
  logic addr_ok;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;

  // Two-stage synchroniser for every pin; only the second stage feeds logic.
  // The die temperature word must change slowly (one code at a time) to cross cleanly.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pins_meta_ff <= '0;
      pins_ff <= '0;
    end else begin
      pins_meta_ff <= pins_in;
      pins_ff <= pins_meta_ff;
    end
  end

  // Zone decode from the synchronised comparators; cold, then cool, then over-hot take priority.
  always_comb begin
    if (pins_ff.ntc_below_0c) begin
      nxt_zone = CSUP_ZONE_COLD;
    end else if (pins_ff.ntc_below_10c) begin
      nxt_zone = CSUP_ZONE_COOL;
    end else if (pins_ff.ntc_above_60c) begin
      nxt_zone = CSUP_ZONE_OVER;
    end else if (pins_ff.ntc_above_50c) begin
      nxt_zone = CSUP_ZONE_HOT;
    end else if (pins_ff.ntc_above_45c) begin
      nxt_zone = CSUP_ZONE_WARM;
    end else begin
      nxt_zone = CSUP_ZONE_NORMAL;
    end
  end

  // The zone register makes each crossing effective on the following clock.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      zone_ff <= CSUP_ZONE_NORMAL;
    end else begin
      zone_ff <= nxt_zone;
    end
  end

  // Zone policy: which zones suspend charging and which halve currents and timers.
  assign zone_suspend = (zone_ff == CSUP_ZONE_COLD)
    || (zone_ff == CSUP_ZONE_OVER)
    || (((zone_ff == CSUP_ZONE_WARM) || (zone_ff == CSUP_ZONE_HOT)) && zone_opt_ff);
  assign zone_half = (zone_ff == CSUP_ZONE_COOL) && zone_opt_ff;

  // Manual mode lets software force the charger on or off over the automatic condition.
  assign enabled = ctrl_ff[CSUP_CTRL_MANUAL_BIT] ? ctrl_ff[CSUP_CTRL_EN_BIT]
                                                 : pins_ff.vsys_above_bat;

  // Die derating: linear from full current at the start point to zero at the end point.
  assign derate_active = !ctrl_ff[CSUP_CTRL_DERATE_DIS_BIT]
                         && (pins_ff.die_temp_c >= CSUP_DIE_DERATE_C);
  assign die_ot = pins_ff.die_temp_c >= CSUP_DIE_OT_C;
  assign derate_diff = {8'h00, CSUP_DIE_ZERO_C} - {8'h00, pins_ff.die_temp_c};
  assign derate_prod = (derate_diff * CSUP_PCT_FULL_W) / CSUP_DIE_SPAN_C;

  always_comb begin
    if (!derate_active) begin
      nxt_derate_pct = CSUP_PCT_FULL;
    end else if (pins_ff.die_temp_c >= CSUP_DIE_ZERO_C) begin
      nxt_derate_pct = CSUP_PCT_ZERO;
    end else begin
      nxt_derate_pct = derate_prod[6:0];
    end
  end

  // One-second tick prescaler shared by both safety timers.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_ff <= '0;
    end else if (tick) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
    end
  end
  assign tick = tick_cnt_ff == (TICK_CYCLES - 1);

  // Half speed is every second tick; the phase keeps toggling so a slow stretch stays exact.
  assign slow_timers = zone_half || pins_ff.vin_reg_active || pins_ff.iin_reg_active
                       || derate_active;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      half_ph_ff <= 1'b0;
    end else if (tick) begin
      half_ph_ff <= !half_ph_ff;
    end
  end
  assign count_en = tick && (!slow_timers || half_ph_ff);

  // Supervisor state machine: a disable ends a fault and restarts the cycle.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      CSUP_ST_IDLE: begin
        if (enabled) begin
          nxt_state = CSUP_ST_RUN;
        end
      end
      CSUP_ST_RUN: begin
        if (!enabled) begin
          nxt_state = CSUP_ST_IDLE;
        end else if (die_ot || pre_expired || fast_expired) begin
          nxt_state = CSUP_ST_FAULT;
        end else if (zone_suspend) begin
          nxt_state = CSUP_ST_SUSPEND;
        end
      end
      CSUP_ST_SUSPEND: begin
        if (!enabled) begin
          nxt_state = CSUP_ST_IDLE;
        end else if (die_ot) begin
          nxt_state = CSUP_ST_FAULT;
        end else if (!zone_suspend) begin
          nxt_state = CSUP_ST_RUN;
        end
      end
      default: begin
        if (!enabled) begin
          nxt_state = CSUP_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= CSUP_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign pre_expired = pre_cnt_ff >= CSUP_PRE_LIMIT_S;
  assign fast_expired = fast_cnt_ff >= CSUP_FAST_LIMIT_S;

  // Safety timers: cleared only when the charger is idle, held while suspended.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_cnt_ff <= CSUP_TMR_ZERO;
      fast_cnt_ff <= CSUP_TMR_ZERO;
    end else if (state_ff == CSUP_ST_IDLE) begin
      pre_cnt_ff <= CSUP_TMR_ZERO;
      fast_cnt_ff <= CSUP_TMR_ZERO;
    end else if ((state_ff == CSUP_ST_RUN) && count_en) begin
      if (pins_ff.bat_below_vpre && !pre_expired) begin
        pre_cnt_ff <= pre_cnt_ff + CSUP_TMR_ONE;
      end
      if (!pins_ff.bat_below_vpre && !fast_expired) begin
        fast_cnt_ff <= fast_cnt_ff + CSUP_TMR_ONE;
      end
    end
  end

  // Sticky fault and level overtemperature status for software.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      die_ot_ff <= 1'b0;
      fault_ff <= 1'b0;
    end else begin
      die_ot_ff <= die_ot;
      fault_ff <= die_ot || (nxt_state == CSUP_ST_FAULT);
    end
  end

  // Commands to the charge loop, all registered.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmd_ff <= '0;
    end else begin
      cmd_ff.charge_run <= nxt_state == CSUP_ST_RUN;
      cmd_ff.current_half <= zone_half;
      cmd_ff.derate_pct <= nxt_derate_pct;
      cmd_ff.cord_comp_setting <= ctrl_ff[CSUP_CTRL_CORD_MSB:CSUP_CTRL_CORD_LSB];
      cmd_ff.fault <= die_ot || (nxt_state == CSUP_ST_FAULT);
      if ((zone_ff == CSUP_ZONE_WARM) && !zone_opt_ff) begin
        cmd_ff.vterm_drop_mv <= CSUP_VTERM_WARM_MV;
      end else if ((zone_ff == CSUP_ZONE_HOT) && !zone_opt_ff) begin
        cmd_ff.vterm_drop_mv <= CSUP_VTERM_HOT_MV;
      end else begin
        cmd_ff.vterm_drop_mv <= CSUP_VTERM_NONE_MV;
      end
    end
  end

  // Previous values for change detection of host-visible conditions.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      zone_prev_ff <= CSUP_ZONE_NORMAL;
      prev_bits_ff <= '0;
      phase_prev_ff <= '0;
    end else begin
      zone_prev_ff <= zone_ff;
      prev_bits_ff <= {fault_ff, die_ot_ff, pins_ff.source_present, pins_ff.ntc_present,
                       pins_ff.bat_low};
      phase_prev_ff <= pins_ff.charge_phase;
    end
  end

  // Event pulses: presence follows the thermistor pull-down detection.
  assign events[CSUP_EV_ZONE] = zone_ff != zone_prev_ff;
  assign events[CSUP_EV_BAT_LOW] = pins_ff.bat_low && !prev_bits_ff[0];
  assign events[CSUP_EV_PRESENCE] = pins_ff.ntc_present != prev_bits_ff[1];
  assign events[CSUP_EV_SOURCE] = pins_ff.source_present != prev_bits_ff[2];
  assign events[CSUP_EV_PHASE] = pins_ff.charge_phase != phase_prev_ff;
  assign events[CSUP_EV_DIE_OT] = die_ot_ff && !prev_bits_ff[3];
  assign events[CSUP_EV_FAULT] = fault_ff && !prev_bits_ff[4];

  // Sticky interrupt status, write one to clear; a new event wins over the clear.
  always_comb begin
    nxt_int_stat = int_stat_ff;
    if (wr_commit && (paddr == CSUP_INT_STAT_OFS)) begin
      nxt_int_stat = nxt_int_stat & ~pwdata[CSUP_EV_NUM-1:0];
    end
    nxt_int_stat = nxt_int_stat | events;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      int_stat_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      int_stat_ff <= nxt_int_stat;
      irq_ff <= |(nxt_int_stat & int_mask_ff);
    end
  end

  // APB: one wait state, access taken and write applied on the edge with pready high.
  assign apb_access = psel && penable && !pready_ff;
  assign apb_commit = psel && penable && pready_ff;
  assign wr_commit = apb_commit && pwrite;

  // Read decode; unmapped addresses answer with an error and zero data.
  always_comb begin
    rd_data = '0;
    addr_ok = 1'b1;
    if (paddr == CSUP_CTRL_OFS) begin
      rd_data[6:0] = ctrl_ff;
    end else if (paddr == CSUP_STATUS_OFS) begin
      rd_data[13:0] = {derate_active, pins_ff.bat_low, pins_ff.source_present,
                       pins_ff.charge_phase, pins_ff.ntc_present, state_ff, zone_ff,
                       fault_ff, die_ot_ff};
    end else if (paddr == CSUP_INT_STAT_OFS) begin
      rd_data[CSUP_EV_NUM-1:0] = int_stat_ff;
    end else if (paddr == CSUP_INT_MASK_OFS) begin
      rd_data[CSUP_EV_NUM-1:0] = int_mask_ff;
    end else if (paddr == CSUP_PRE_TMR_OFS) begin
      rd_data[13:0] = pre_cnt_ff;
    end else if (paddr == CSUP_FAST_TMR_OFS) begin
      rd_data[13:0] = fast_cnt_ff;
    end else if (paddr == CSUP_ZONE_CFG_OFS) begin
      rd_data[CSUP_ZONE_OPT_BIT] = zone_opt_ff;
    end else begin
      addr_ok = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= apb_access;
      pslverr_ff <= apb_access && !addr_ok;
      prdata_ff <= (apb_access && !pwrite) ? rd_data : 32'h0000_0000;
    end
  end
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // Writable registers.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= CSUP_CTRL_RST;
      zone_opt_ff <= 1'b0;
      int_mask_ff <= '0;
    end else if (wr_commit) begin
      if (paddr == CSUP_CTRL_OFS) begin
        ctrl_ff <= pwdata[6:0];
      end else if (paddr == CSUP_ZONE_CFG_OFS) begin
        zone_opt_ff <= pwdata[CSUP_ZONE_OPT_BIT];
      end else if (paddr == CSUP_INT_MASK_OFS) begin
        int_mask_ff <= pwdata[CSUP_EV_NUM-1:0];
      end
    end
  end

  // Checks on the supervisor's own behaviour.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence seq_fault_stop;
    ((state_ff == CSUP_ST_FAULT) && cmd_ff.fault && !cmd_ff.charge_run) ##1 !cmd_ff.charge_run;
  endsequence

  AST_DIE_ZERO: assert property (derate_active && (pins_ff.die_temp_c >= CSUP_DIE_ZERO_C)
    |=> cmd_ff.derate_pct == CSUP_PCT_ZERO) else $error("Derate not zero at end point.");
  AST_DIE_OT: assert property (die_ot && enabled && (state_ff == CSUP_ST_RUN)
    |=> seq_fault_stop) else $error("Overtemperature did not fault.");
  AST_DERATE_OFF: assert property (ctrl_ff[CSUP_CTRL_DERATE_DIS_BIT]
    |=> cmd_ff.derate_pct == CSUP_PCT_FULL) else $error("Derating active while disabled.");
  AST_COLD: assert property ((state_ff == CSUP_ST_RUN) && (zone_ff == CSUP_ZONE_COLD)
    && enabled && !die_ot && !pre_expired && !fast_expired
    |=> (state_ff == CSUP_ST_SUSPEND) && !cmd_ff.charge_run) else $error("Cold not suspended.");
  AST_HOLD: assert property ((state_ff == CSUP_ST_SUSPEND)
    |=> $stable(pre_cnt_ff) && $stable(fast_cnt_ff)) else $error("Timer moved in suspend.");
  AST_HALF: assert property ((state_ff == CSUP_ST_RUN) && tick && slow_timers && !half_ph_ff
    |=> $stable(pre_cnt_ff) && $stable(fast_cnt_ff)) else $error("Timer ran at full speed.");
  AST_PRE_EXP: assert property ((state_ff == CSUP_ST_RUN) && enabled && pre_expired
    |=> seq_fault_stop) else $error("Precondition expiry missed.");
  AST_FAST_EXP: assert property ((state_ff == CSUP_ST_RUN) && enabled && fast_expired
    |=> seq_fault_stop) else $error("Fast timer expiry missed.");
  AST_WARM: assert property ((zone_ff == CSUP_ZONE_WARM) && !zone_opt_ff
    |=> cmd_ff.vterm_drop_mv == CSUP_VTERM_WARM_MV) else $error("Warm zone drop wrong.");
  AST_ZONE_IRQ: assert property (events[CSUP_EV_ZONE] && int_mask_ff[CSUP_EV_ZONE]
    |=> irq_ff && int_stat_ff[CSUP_EV_ZONE]) else $error("Zone change raised no interrupt.");
  AST_APB_WAIT: assert property (apb_access |=> pready_ff ##1 !pready_ff)
    else $error("APB answer not one cycle.");

endmodule : csup_supervisor

//--- verification/csup_host_model.sv
// Host processor model: an APB master that reads status and clears interrupts.
module csup_host_model (
  input wire logic sys_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // One transfer. It starts a cycle late so that a release never meets a new setup.
  // It waits for pready as long as it takes; only the bench timeout ends a hang.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : csup_host_model

//--- verification/tb_charger_safety_supervisor.sv
// Self-checking bench of the charger safety supervisor.
module tb_charger_safety_supervisor;
  import csup_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  csup_pins_t pins;
  logic psel, penable, pwrite, pready, pslverr, irq_ff, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, t;
  csup_cmd_t cmd_ff;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int seed;
  int c;

  always #2.5 sys_clk = ~sys_clk;

  // The tick is shortened to four cycles so that both timers can expire in one run.
  csup_supervisor #(.TICK_CYCLES(4)) i_dut (.sys_clk(sys_clk), .rst(rst), .pins_in(pins),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_ff(cmd_ff), .irq_ff(irq_ff));

  csup_host_model i_host (.sys_clk(sys_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, q, e);
    check(e, 32'h0000_0000);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    i_host.xfer(1'b0, a, 32'h0000_0000, q, e);
    check(e, 32'h0000_0000);
  endtask : rd

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wait_cyc

  // Nested comparator levels: 0 cold, 1 cool, 2 normal, 3 warm, 4 hot, 5 over.
  task automatic set_zone(input int z);
    @(posedge sys_clk);
    pins.ntc_below_0c <= (z == 0);
    pins.ntc_below_10c <= (z <= 1);
    pins.ntc_above_45c <= (z >= 3);
    pins.ntc_above_50c <= (z >= 4);
    pins.ntc_above_60c <= (z == 5);
    wait_cyc(8);
  endtask : set_zone

  // Reference policy of the temperature zones.
  function automatic int exp_run(input int z, input int o);
    return !(z == 0 || z == 5 || (o != 0 && z >= 3));
  endfunction : exp_run

  function automatic int exp_drop(input int z, input int o);
    return (o != 0 || z < 3 || z == 5) ? 0 : ((z == 3) ? 100 : 150);
  endfunction : exp_drop

  function automatic int exp_derate(input int tc);
    return (tc < 115) ? 100 : ((tc >= 150) ? 0 : (150 - tc) * 100 / 35);
  endfunction : exp_derate

  // Expiry window of a timer started now: quiet just before, fault just after.
  task automatic expiry(input int ticks);
    wait_cyc(ticks * 4 - 40);
    check(cmd_ff.fault, 32'h0000_0000);
    wait_cyc(80);
    check(cmd_ff.fault, 32'h0000_0001);
    check(cmd_ff.charge_run, 32'h0000_0000);
  endtask : expiry

  task automatic restart;
    wr(CSUP_CTRL_OFS, 32'h0000_0004);
    wr(CSUP_CTRL_OFS, 32'h0000_0001);
  endtask : restart

  // A hang is cut short well above the longest expected run.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_errors++;
      $display("wrong value at %0t: timeout", $time);
      tally_and_finish();
    end
  end

  initial begin
    seed = 32'he6a3;
    pins = '0;
    pins.ntc_present = 1'b1;
    pins.vsys_above_bat = 1'b1;
    pins.source_present = 1'b1;
    pins.die_temp_c = 8'h64;
    wait_cyc(12);
    rst <= 1'b0;
    rd(CSUP_CTRL_OFS); check(q, 32'h0000_0001);
    rd(CSUP_INT_MASK_OFS); check(q, 32'h0000_0000);
    i_host.xfer(1'b0, 12'h020, 32'h0000_0000, q, e);
    check({q[30:0], e}, 32'h0000_0001);
    set_zone(2);
    rd(CSUP_STATUS_OFS); check(q[7], 32'h0000_0001);
    // Zone changes are unmasked during the zone sweep so that they reach the interrupt line.
    wr(CSUP_INT_MASK_OFS, 32'h0000_0001);
    for (int k = 0; k < 12; k++) begin
      wr(CSUP_ZONE_CFG_OFS, (k % 2) << CSUP_ZONE_OPT_BIT);
      set_zone(k / 2);
      check(cmd_ff.charge_run, exp_run(k / 2, k % 2));
      if (exp_run(k / 2, k % 2) != 0) begin
        check(cmd_ff.current_half, (k == 3));
        check(cmd_ff.vterm_drop_mv, exp_drop(k / 2, k % 2));
      end
    end
    check(irq_ff, 32'h0000_0001);
    set_zone(2);
    c = $random(seed) & 7;
    wr(CSUP_CTRL_OFS, 32'h0000_0001 | (c << CSUP_CTRL_CORD_LSB));
    wait_cyc(3);
    check(cmd_ff.cord_comp_setting, c);
    wr(CSUP_INT_MASK_OFS, 32'h0000_0020);
    for (int tc = 101; tc <= 155; tc++) begin
      @(posedge sys_clk);
      pins.die_temp_c <= tc[7:0];
      wait_cyc(6);
      check(cmd_ff.derate_pct, exp_derate(tc));
      if (tc == 150) begin
        wr(CSUP_CTRL_OFS, 32'h0000_0003);
        wait_cyc(3);
        check(cmd_ff.derate_pct, 32'h0000_0064);
        wr(CSUP_CTRL_OFS, 32'h0000_0001);
      end
    end
    rd(CSUP_STATUS_OFS); check(q[1:0], 32'h0000_0003);
    check({irq_ff, cmd_ff.fault}, 32'h0000_0003);
    wr(CSUP_INT_STAT_OFS, 32'h0000_0020);
    wait_cyc(2);
    check(irq_ff, 32'h0000_0000);
    for (int tc = 154; tc >= 100; tc--) begin
      @(posedge sys_clk);
      pins.die_temp_c <= tc[7:0];
    end
    // Battery, source, presence and phase events each set their own status bit.
    wr(CSUP_INT_STAT_OFS, 32'h0000_007f);
    pins.bat_low <= 1'b1;
    pins.charge_phase <= 3'b001;
    pins.source_present <= 1'b0;
    pins.ntc_present <= 1'b0;
    wait_cyc(6);
    rd(CSUP_INT_STAT_OFS); check(q, 32'h0000_001e);
    rd(CSUP_STATUS_OFS); check(q[7], 32'h0000_0000);
    pins.source_present <= 1'b1;
    pins.ntc_present <= 1'b1;
    wr(CSUP_CTRL_OFS, 32'h0000_0004);
    pins.bat_below_vpre <= 1'b1;
    wr(CSUP_CTRL_OFS, 32'h0000_0001);
    wait_cyc(2000);
    set_zone(0);
    rd(CSUP_PRE_TMR_OFS); t = q;
    wait_cyc(200);
    rd(CSUP_PRE_TMR_OFS); check(q, t);
    set_zone(2);
    expiry(4000 - int'(t) - 3);
    pins.bat_below_vpre <= 1'b0;
    pins.vin_reg_active <= 1'b1;
    restart();
    wait_cyc(800);
    rd(CSUP_FAST_TMR_OFS); t = q;
    check(t >= 95 && t <= 110, 32'h0000_0001);
    pins.vin_reg_active <= 1'b0;
    expiry(12000 - int'(t));
    tally_and_finish();
  end
endmodule : tb_charger_safety_supervisor
